// File: tx_radio_state_controller.sv
// Radio control state machine, transmit FIFO bookkeeping and synth word.
// Assumes strobes are one-cycle pulses from the serial front end on clk_i.
module tx_radio_state_controller #(
   parameter int unsigned CAL_CYCLES = radio_ctrl_pkg::CAL_PERIODS,
   parameter int unsigned SETTLE_CYCLES = radio_ctrl_pkg::SETTLE_PERIODS
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic chip_select_n_i,
   input wire logic power_down_strobe_i,
   input wire logic transmit_strobe_i,
   input wire logic manual_calibrate_strobe_i,
   input wire logic go_idle_strobe_i,
   input wire logic cfg_write_i,
   input wire logic [3:0] powerup_timeout_field_i,
   input wire logic [1:0] auto_cal_select_i,
   input wire logic [1:0] after_tx_state_select_i,
   input wire logic [3:0] buffer_threshold_code_i,
   input wire logic [23:0] carrier_base_i,
   input wire logic [7:0] hop_index_i,
   input wire logic [7:0] spacing_mantissa_i,
   input wire logic [1:0] spacing_exponent_i,
   input wire logic fifo_write_i,
   input wire logic fifo_read_i,
   input wire logic packet_done_i,
   output logic [2:0] radio_state_o,
   output logic core_regulator_en_o,
   output logic crystal_oscillator_en_o,
   output logic synth_on_o,
   output logic transmitting_o,
   output logic calibrating_o,
   output logic cal_valid_o,
   output logic underflow_o,
   output logic threshold_flag_o,
   output logic [6:0] tx_fill_count_o,
   output logic [3:0] powerup_timeout_field_o,
   output logic [3:0] buffer_threshold_code_o,
   output logic [33:0] synth_word_o
);
   typedef radio_ctrl_pkg::radio_state_type radio_state_type;
   localparam radio_state_type ST_IDLE = radio_ctrl_pkg::ST_IDLE;
   localparam radio_state_type ST_SLEEP = radio_ctrl_pkg::ST_SLEEP;
   localparam radio_state_type ST_SETTLE = radio_ctrl_pkg::ST_SETTLE;
   localparam radio_state_type ST_CAL_IN = radio_ctrl_pkg::ST_CAL_IN;
   localparam radio_state_type ST_SYNTH_READY = radio_ctrl_pkg::ST_SYNTH_READY;
   localparam radio_state_type ST_TX = radio_ctrl_pkg::ST_TX;
   localparam radio_state_type ST_CAL_OUT = radio_ctrl_pkg::ST_CAL_OUT;
   localparam radio_state_type ST_CAL_MAN = radio_ctrl_pkg::ST_CAL_MAN;
   localparam radio_ctrl_pkg::auto_cal_type CAL_ON_ENTER = radio_ctrl_pkg::CAL_ON_ENTER;
   localparam radio_ctrl_pkg::auto_cal_type CAL_ON_LEAVE = radio_ctrl_pkg::CAL_ON_LEAVE;
   localparam radio_ctrl_pkg::auto_cal_type CAL_EVERY_FOURTH = radio_ctrl_pkg::CAL_EVERY_FOURTH;
   localparam radio_ctrl_pkg::after_tx_type AFTER_SYNTH_READY = radio_ctrl_pkg::AFTER_SYNTH_READY;
   localparam radio_ctrl_pkg::after_tx_type AFTER_TX = radio_ctrl_pkg::AFTER_TX;

   typedef struct packed {
      logic cs_meta;
      logic cs_sync;
      radio_state_type st;
      logic pd_armed;
      logic [14:0] cnt;
      logic [1:0] leave_cnt;
      logic cal_valid;
      logic underflow;
      logic thr_flag;
      logic [6:0] fill;
      logic [3:0] powerup_timeout_field;
      logic [3:0] thr_code;
      logic [23:0] base;
      logic [7:0] hop;
      logic [7:0] mant;
      logic [1:0] expo;
      logic [33:0] word;
      logic reg_on;
      logic synth;
      logic txing;
      logic cal_busy;
   } state_type;

   localparam logic [14:0] CAL_LAST = 15'(CAL_CYCLES - 1);
   localparam logic [14:0] SETTLE_LAST = 15'(SETTLE_CYCLES - 1);
   localparam logic [6:0] DEPTH = 7'(radio_ctrl_pkg::FIFO_DEPTH);

   state_type s_reg;
   state_type s_next;
   logic [6:0] thr_bytes;
   logic [17:0] spacing;
   logic wr_ok;
   logic rd_ok;

   always_comb
   begin
      s_next = s_reg;
      s_next.cs_meta = chip_select_n_i;
      s_next.cs_sync = s_reg.cs_meta;
      thr_bytes = 7'(radio_ctrl_pkg::THR_BASE) - {1'b0, s_reg.thr_code, 2'b00};
      wr_ok = fifo_write_i && s_reg.st != ST_SLEEP;
      rd_ok = fifo_read_i && s_reg.st == ST_TX && s_reg.fill != 7'h00;
      if (wr_ok && !rd_ok && s_reg.fill != DEPTH)
      begin
         s_next.fill = s_reg.fill + 7'h01;
      end
      else if (rd_ok && !wr_ok)
      begin
         s_next.fill = s_reg.fill - 7'h01;
      end
      if (cfg_write_i && s_reg.st == ST_IDLE)
      begin
         s_next.powerup_timeout_field = powerup_timeout_field_i;
         s_next.thr_code = buffer_threshold_code_i;
         s_next.base = carrier_base_i;
         s_next.hop = hop_index_i;
         s_next.mant = spacing_mantissa_i;
         s_next.expo = spacing_exponent_i;
      end
      spacing = 18'(({10'h000, s_reg.mant} + 18'(radio_ctrl_pkg::SPACING_BASE)) << s_reg.expo);
      s_next.word = 34'({8'h00, s_reg.base, 2'b00} + {8'h00, s_reg.hop} * {16'h0000, spacing}) ;
      s_next.cnt = s_reg.cnt + 15'h0001;
      unique case (s_reg.st)
         ST_IDLE:
         begin
            s_next.cnt = 15'h0000;
            if (power_down_strobe_i)
            begin
               s_next.pd_armed = 1'b1;
            end
            if (s_reg.pd_armed && s_reg.cs_sync)
            begin
               s_next.st = ST_SLEEP;
               s_next.pd_armed = 1'b0;
            end
            else if (transmit_strobe_i)
            begin
               s_next.st = (s_reg.cal_valid == 1'b0 || auto_cal_select_i == 2'(CAL_ON_ENTER)) ? ST_CAL_IN : ST_SETTLE;
            end
            else if (manual_calibrate_strobe_i)
            begin
               s_next.st = ST_CAL_MAN;
            end
         end
         ST_SLEEP:
         begin
            if (!s_reg.cs_sync)
            begin
               s_next.st = ST_IDLE;
            end
            s_next.thr_code = radio_ctrl_pkg::THRESHOLD_CODE_RESET;
            s_next.base = radio_ctrl_pkg::CARRIER_BASE_RESET;
            s_next.hop = radio_ctrl_pkg::HOP_INDEX_RESET;
            s_next.mant = radio_ctrl_pkg::SPACING_MANTISSA_RESET;
            s_next.expo = radio_ctrl_pkg::SPACING_EXPONENT_RESET;
            s_next.fill = 7'h00;
            s_next.thr_flag = 1'b0;
            s_next.underflow = 1'b0;
            s_next.leave_cnt = 2'h0;
            s_next.cal_valid = 1'b0;
         end
         ST_CAL_IN:
         begin
            if (s_reg.cnt == CAL_LAST)
            begin
               s_next.cnt = 15'h0000;
               s_next.cal_valid = 1'b1;
               s_next.st = ST_SETTLE;
            end
         end
         ST_SETTLE:
         begin
            if (s_reg.cnt == SETTLE_LAST)
            begin
               s_next.cnt = 15'h0000;
               s_next.st = ST_TX;
            end
         end
         ST_SYNTH_READY:
         begin
            if (transmit_strobe_i)
            begin
               s_next.st = ST_TX;
            end
         end
         ST_TX:
         begin
            s_next.cnt = 15'h0000;
            if (fifo_read_i && s_reg.fill == 7'h00)
            begin
               s_next.underflow = 1'b1;
               s_next.st = ST_IDLE;
            end
            else if (packet_done_i)
            begin
               unique case (after_tx_state_select_i)
                  2'(AFTER_SYNTH_READY): s_next.st = ST_SYNTH_READY;
                  2'(AFTER_TX): s_next.st = ST_TX;
                  default:
                  begin
                     s_next.leave_cnt = s_reg.leave_cnt + 2'h1;
                     if (auto_cal_select_i == 2'(CAL_ON_LEAVE) ||
                         (auto_cal_select_i == 2'(CAL_EVERY_FOURTH) && s_reg.leave_cnt == 2'h3))
                     begin
                        s_next.st = ST_CAL_OUT;
                     end
                     else
                     begin
                        s_next.st = ST_IDLE;
                     end
                  end
               endcase
            end
         end
         ST_CAL_OUT, ST_CAL_MAN:
         begin
            if (s_reg.cnt == CAL_LAST)
            begin
               s_next.cnt = 15'h0000;
               s_next.cal_valid = 1'b1;
               s_next.st = ST_IDLE;
            end
         end
      endcase
      if (go_idle_strobe_i && s_reg.st != ST_SLEEP)
      begin
         s_next.st = ST_IDLE;
         s_next.cnt = 15'h0000;
         s_next.cal_valid = s_reg.cal_valid;
      end
      if (transmit_strobe_i && s_reg.st == ST_IDLE)
      begin
         s_next.underflow = 1'b0;
      end
      s_next.thr_flag = s_next.fill >= 7'(radio_ctrl_pkg::THR_BASE) - {1'b0, s_next.thr_code, 2'b00};
      // Registered state decode
      s_next.reg_on = s_next.st != ST_SLEEP;
      s_next.synth = s_next.st inside {ST_SETTLE, ST_SYNTH_READY, ST_TX};
      s_next.txing = s_next.st == ST_TX;
      s_next.cal_busy = s_next.st inside {ST_CAL_IN, ST_CAL_OUT, ST_CAL_MAN};
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s_reg <= '{cs_meta: 1'b1, cs_sync: 1'b1, st: ST_IDLE, powerup_timeout_field: radio_ctrl_pkg::POWERUP_TIMEOUT_RESET,
                    thr_code: radio_ctrl_pkg::THRESHOLD_CODE_RESET, expo: radio_ctrl_pkg::SPACING_EXPONENT_RESET,
                    reg_on: 1'b1, default: '0};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign radio_state_o = s_reg.st;
   assign core_regulator_en_o = s_reg.reg_on;
   assign crystal_oscillator_en_o = s_reg.reg_on;
   assign synth_on_o = s_reg.synth;
   assign transmitting_o = s_reg.txing;
   assign calibrating_o = s_reg.cal_busy;
   assign cal_valid_o = s_reg.cal_valid;
   assign underflow_o = s_reg.underflow;
   assign tx_fill_count_o = s_reg.fill;
   assign threshold_flag_o = s_reg.thr_flag;
   assign powerup_timeout_field_o = s_reg.powerup_timeout_field;
   assign buffer_threshold_code_o = s_reg.thr_code;
   assign synth_word_o = s_reg.word;

   property p_idle_strobe;
      @(posedge clk_i) disable iff (!reset_n_i)
      go_idle_strobe_i && s_reg.st != ST_SLEEP |=> s_reg.st == ST_IDLE;
   endproperty
   a_idle_strobe: assert property (p_idle_strobe) else $error("Idle strobe did not reach idle");

   sequence s_tx_to_idle_skip;
      s_reg.st == ST_TX && go_idle_strobe_i;
   endsequence
   property p_skip_cal;
      @(posedge clk_i) disable iff (!reset_n_i)
      s_tx_to_idle_skip |=> !calibrating_o [*2];
   endproperty
   a_skip_cal: assert property (p_skip_cal) else $error("Calibration after idle strobe");

   property p_sleep_entry;
      @(posedge clk_i) disable iff (!reset_n_i)
      s_reg.st == ST_IDLE && s_reg.pd_armed && s_reg.cs_sync && !go_idle_strobe_i |=> !core_regulator_en_o;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("Sleep not entered");

   property p_wake;
      @(posedge clk_i) disable iff (!reset_n_i)
      s_reg.st == ST_SLEEP && !s_reg.cs_sync |=> s_reg.st == ST_IDLE && !cal_valid_o;
   endproperty
   a_wake: assert property (p_wake) else $error("Wake did not reach idle");

   property p_cal_len;
      @(posedge clk_i) disable iff (!reset_n_i)
      $rose(calibrating_o) |-> s_reg.cnt == 15'h0000;
   endproperty
   a_cal_len: assert property (p_cal_len) else $error("Calibration counter not cleared");

   property p_cal_end;
      @(posedge clk_i) disable iff (!reset_n_i)
      calibrating_o && s_reg.cnt == CAL_LAST |=> !calibrating_o;
   endproperty
   a_cal_end: assert property (p_cal_end) else $error("Calibration overran");

   property p_thr;
      @(posedge clk_i) disable iff (!reset_n_i)
      threshold_flag_o == (tx_fill_count_o >= thr_bytes);
   endproperty
   a_thr: assert property (p_thr) else $error("Threshold flag mismatch");

   property p_fill_max;
      @(posedge clk_i) disable iff (!reset_n_i)
      tx_fill_count_o <= DEPTH;
   endproperty
   a_fill_max: assert property (p_fill_max) else $error("Fill count above depth");

   property p_underflow;
      @(posedge clk_i) disable iff (!reset_n_i)
      s_reg.st == ST_TX && fifo_read_i && s_reg.fill == 7'h00 |=> underflow_o && s_reg.st == ST_IDLE;
   endproperty
   a_underflow: assert property (p_underflow) else $error("Underflow not handled");

   property p_tx_strobe;
      @(posedge clk_i) disable iff (!reset_n_i)
      s_reg.st == ST_SYNTH_READY && transmit_strobe_i && !go_idle_strobe_i |=> transmitting_o;
   endproperty
   a_tx_strobe: assert property (p_tx_strobe) else $error("Transmit strobe ignored");
endmodule

// File: radio_ctrl_pkg.sv
// Constants, timing counts and state types for the radio state controller.
// Assumes a crystal-rate clock; all timing counts are crystal periods.
// Contract
// - Power-down strobe then chip select high enters sleep, core regulator off.
// - Chip select low in sleep restarts regulator and oscillator, then idle.
// - Sleep clears configuration except power-up timeout; host rewrites after wake.
// - Transmit strobe moves the machine into transmit.
// - Auto-calibration select: on entering transmit, on leaving, or every fourth leave.
// - Transmit lasts until packet done, then idle, synth-ready or transmit again.
// - Synth-ready keeps synthesizer running; transmit strobe starts transmission.
// - Idle strobe forces idle from any state except sleep.
// - Idle strobe exit from transmit skips leave calibration.
// - One calibration lasts 18739 crystal periods.
// - Idle to transmit takes 2298 periods, about 21037 with calibration.
// - Transmit to idle without calibration completes within 2 periods.
// - Sixty-four byte transmit FIFO written by host; underflow is detected.
// - Threshold equals 61 minus four times the 4-bit code.
// - Threshold flag set while fill count is at or above threshold.
// - Fill level reported in the fill-count field.
// - Base carrier word is 24 bits in three bytes; hop index 8 bits.
// - Synth word is base plus index times ((256+mantissa) shifted by exponent-2).
// - Manual calibration strobe in idle starts a calibration.
// - Calibration is lost in sleep; recalibrate after wake.
// - Transmit FIFO underflow also causes a state transition.
package radio_ctrl_pkg;
   localparam int unsigned CAL_PERIODS = 18739;
   localparam int unsigned SETTLE_PERIODS = 2298;
   localparam int unsigned TX_OFF_PERIODS = 2;
   localparam int unsigned FIFO_DEPTH = 64;
   localparam int unsigned THR_BASE = 61;
   localparam int unsigned SPACING_BASE = 256;
   localparam logic [3:0] POWERUP_TIMEOUT_RESET = 4'h1;
   localparam logic [23:0] CARRIER_BASE_RESET = 24'h00_0000;
   localparam logic [7:0] HOP_INDEX_RESET = 8'h00;
   localparam logic [7:0] SPACING_MANTISSA_RESET = 8'h00;
   localparam logic [1:0] SPACING_EXPONENT_RESET = 2'h2;
   localparam logic [3:0] THRESHOLD_CODE_RESET = 4'h7;

   typedef enum logic [1:0] {CAL_NEVER, CAL_ON_ENTER, CAL_ON_LEAVE, CAL_EVERY_FOURTH} auto_cal_type;
   typedef enum logic [1:0] {AFTER_IDLE, AFTER_SYNTH_READY, AFTER_TX, AFTER_RSVD} after_tx_type;
   typedef enum logic [2:0] {ST_IDLE, ST_SLEEP, ST_SETTLE, ST_CAL_IN, ST_SYNTH_READY, ST_TX, ST_CAL_OUT,
                             ST_CAL_MAN} radio_state_type;
endpackage

// File: host_model.sv
// Host side model: chip select on a slow link clock, FIFO and config writes.
// Assumes the controller's fill count and idle decode as inputs.
module host_model (
   input wire logic link_clk_i,
   input wire logic cs_req_i,
   input wire logic wr_req_i,
   input wire logic cfg_req_i,
   input wire logic idle_i,
   input wire logic [6:0] fill_i,
   output logic chip_select_n_o,
   output logic fifo_write_o,
   output logic cfg_write_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic cs_n_q = 1'b0;
   always @(posedge link_clk_i)
   begin
      cs_n_q <= !cs_req_i;
   end
   assign chip_select_n_o = cs_n_q;
   assign fifo_write_o = wr_req_i && (fill_i < 7'h40);
   assign cfg_write_o = cfg_req_i && idle_i;
endmodule

// File: tx_radio_state_controller_tb.sv
// Self-checking bench for the radio state controller with a host model.
// Assumes short calibration and settle counts set by parameter.
module tx_radio_state_controller_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int CAL = 20;
   localparam int SET = 10;
   logic clk_i = 0, reset_n_i = 0, link_clk = 0, cs_req = 1, cfg_req = 0;
   logic [6:0] sb = 7'h00;
   logic [3:0] pto = 4'h1, thr = 4'h7, pto_o, thr_o;
   logic [1:0] acal = 2'h0, atx = 2'h0, sexp = 2'h2;
   logic [23:0] base = 24'h00_0000;
   logic [7:0] hop = 8'h00, mant = 8'h00;
   logic [2:0] st;
   logic chip_select_n, fw, cw, reg_en, osc_en, syn, txg, calg, calv, unf, thf;
   logic [6:0] fill;
   logic [33:0] sw, m_sw;
   logic [31:0] seed;
   int fail_count = 0, n_checks = 0, m_fill = 0, m_leave = 0, n, ncal;
   always #20 clk_i = ~clk_i;
   initial
   begin
      #7;
      forever #160 link_clk = ~link_clk;
   end
   host_model u_host_model (.link_clk_i(link_clk), .cs_req_i(cs_req), .wr_req_i(sb[6]), .cfg_req_i(cfg_req),
      .idle_i(st == 3'h0), .fill_i(fill), .chip_select_n_o(chip_select_n), .fifo_write_o(fw), .cfg_write_o(cw));
   tx_radio_state_controller #(.CAL_CYCLES(CAL), .SETTLE_CYCLES(SET)) u_tx_radio_state_controller (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .chip_select_n_i(chip_select_n), .power_down_strobe_i(sb[0]),
      .transmit_strobe_i(sb[1]), .manual_calibrate_strobe_i(sb[2]), .go_idle_strobe_i(sb[3]),
      .cfg_write_i(cw), .powerup_timeout_field_i(pto), .auto_cal_select_i(acal), .after_tx_state_select_i(atx),
      .buffer_threshold_code_i(thr), .carrier_base_i(base), .hop_index_i(hop), .spacing_mantissa_i(mant),
      .spacing_exponent_i(sexp), .fifo_write_i(fw), .fifo_read_i(sb[4]), .packet_done_i(sb[5]),
      .radio_state_o(st), .core_regulator_en_o(reg_en), .crystal_oscillator_en_o(osc_en), .synth_on_o(syn),
      .transmitting_o(txg), .calibrating_o(calg), .cal_valid_o(calv), .underflow_o(unf),
      .threshold_flag_o(thf), .tx_fill_count_o(fill), .powerup_timeout_field_o(pto_o),
      .buffer_threshold_code_o(thr_o), .synth_word_o(sw));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      n_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic pulse(input int i);
      @(posedge clk_i);
      sb[i] <= 1'b1;
      @(posedge clk_i);
      sb[i] <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic wait_st(input logic [2:0] t, input int lim, output int k);
      k = 0;
      while (st !== t && k < lim)
      begin
         @(negedge clk_i);
         k++;
      end
      if (st !== t)
      begin
         fail_count++;
         $display("CHECK FAILED state expected %0d seen %0d", t, st);
         close_out();
      end
   endtask
   task automatic cfg(input logic [1:0] a, input logic [1:0] x);
      @(posedge clk_i);
      acal <= a;
      atx <= x;
      cfg_req <= 1'b1;
      @(posedge clk_i);
      cfg_req <= 1'b0;
      repeat (2) @(negedge clk_i);
      m_sw = 34'(base) * 34'h4 + 34'(hop) * (34'(mant) + 34'h100 << sexp);
      chk("synth word", m_sw, sw);
   endtask
   task automatic tx_go(input int lo, input int hi);
      pulse(1);
      wait_st(3'h5, hi + 4, n);
      chk("enter time", 1, n + 1 >= lo && n <= hi);
      chk("transmitting", 1, txg);
   endtask
   initial
   begin
      seed = 32'h3967_9f9d;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk("reset state", 0, st);
      chk("cal valid", 0, calv);
      @(posedge clk_i);
      seed = lfsr(seed);
      base <= seed[23:0];
      hop <= seed[31:24];
      mant <= seed[11:4];
      sexp <= seed[13:12];
      thr <= seed[17:14];
      pto <= seed[21:18];
      cfg(2'h0, 2'h0);
      for (int i = 1; i <= 33; i++)
      begin
         pulse(6);
         m_fill = i;
         chk("fill", m_fill, fill);
         chk("thr flag", m_fill >= 61 - 4 * thr, thf);
      end
      for (int c = 0; c < 16; c++)
      begin
         @(posedge clk_i);
         thr <= c[3:0];
         cfg(2'h0, 2'h0);
         chk("thr code", m_fill >= 61 - 4 * c, thf);
      end
      tx_go(CAL + SET - 1, CAL + SET + 2);
      for (int i = 32; i >= 0; i--)
      begin
         pulse(4);
         m_fill = i;
         chk("drain", m_fill, fill);
      end
      pulse(4);
      wait_st(3'h0, 3, n);
      chk("underflow", 1, unf);
      tx_go(SET - 1, SET + 2);
      chk("underflow clear", 0, unf);
      pulse(5);
      wait_st(3'h0, 2, n);
      m_leave++;
      cfg(2'h2, 2'h0);
      tx_go(SET - 1, SET + 2);
      pulse(3);
      wait_st(3'h0, 2, n);
      chk("no leave cal", 0, calg);
      tx_go(SET - 1, SET + 2);
      pulse(5);
      wait_st(3'h6, 3, n);
      m_leave++;
      chk("calibrating", 1, calg);
      wait_st(3'h0, CAL + 4, n);
      chk("leave cal time", 1, n + 2 >= CAL && n <= CAL + 1);
      cfg(2'h1, 2'h1);
      tx_go(CAL + SET - 1, CAL + SET + 2);
      pulse(5);
      wait_st(3'h4, 3, n);
      chk("synth on", 1, syn);
      pulse(1);
      wait_st(3'h5, SET + 4, n);
      pulse(3);
      wait_st(3'h0, 2, n);
      cfg(2'h0, 2'h2);
      tx_go(SET - 1, SET + 2);
      pulse(5);
      repeat (2) @(negedge clk_i);
      chk("tx again", 5, st);
      pulse(3);
      wait_st(3'h0, 2, n);
      cfg(2'h3, 2'h0);
      ncal = 0;
      repeat (4)
      begin
         tx_go(SET - 1, SET + 2);
         pulse(5);
         @(negedge clk_i);
         if (st === 3'h6)
            ncal++;
         chk("fourth cal", m_leave % 4 == 3, st === 3'h6);
         m_leave++;
         wait_st(3'h0, CAL + 4, n);
      end
      chk("fourth cal count", 1, ncal);
      pulse(2);
      wait_st(3'h7, 3, n);
      wait_st(3'h0, CAL + 4, n);
      chk("manual cal time", 1, n + 2 >= CAL && n <= CAL + 1);
      pulse(0);
      cs_req <= 1'b0;
      wait_st(3'h1, 40, n);
      chk("regulator off", 0, reg_en);
      cs_req <= 1'b1;
      wait_st(3'h0, 40, n);
      chk("regulator on", 1, reg_en);
      chk("osc on", 1, osc_en);
      chk("timeout kept", pto, pto_o);
      chk("thr reset", 34'h7, thr_o);
      chk("synth reset", 0, sw);
      chk("cal lost", 0, calv);
      cfg(2'h0, 2'h0);
      tx_go(CAL + SET - 1, CAL + SET + 2);
      close_out();
   end
endmodule
